// ### hw/hbs_cfg.svh
// offsets, reset values, ranges and timing counts for the holding brake sequencer
`ifndef HBS_CFG_SVH
`define HBS_CFG_SVH

// ****************************************************************
// register word offsets
// ****************************************************************
`define HBS_ADDR_W           3
`define HBS_OFS_CMD_DLY      3'h0
`define HBS_OFS_STILL_DLY    3'h1
`define HBS_OFS_SPD_THR      3'h2
`define HBS_OFS_WAIT_TIME    3'h3
`define HBS_OFS_DO_CFG       3'h4
`define HBS_OFS_STATUS       3'h5

// ****************************************************************
// reset values (ms, 0.1 rpm for the threshold, function 18 for the terminal config)
// ****************************************************************
`define HBS_RST_CMD_DLY      16'h00FA
`define HBS_RST_STILL_DLY    16'h0096
`define HBS_RST_SPD_THR      16'h0064
`define HBS_RST_WAIT_TIME    16'h01F4
`define HBS_RST_DO_CFG       16'h0012

// ****************************************************************
// legal ranges, writes are clamped into them
// ****************************************************************
`define HBS_MIN_CMD_DLY      16'h0014
`define HBS_MAX_CMD_DLY      16'h01F4
`define HBS_MIN_STILL_DLY    16'h0001
`define HBS_MAX_STILL_DLY    16'h03E8
`define HBS_MIN_SPD_THR      16'h0000
`define HBS_MAX_SPD_THR      16'h7530
`define HBS_MIN_WAIT_TIME    16'h0001
`define HBS_MAX_WAIT_TIME    16'h7530

// ****************************************************************
// terminal configuration fields
// ****************************************************************
`define HBS_FN_LSB           0
`define HBS_FN_W             5
`define HBS_POL_BIT          8
`define HBS_FN_BRAKE         5'h12

// ****************************************************************
// timing
// ****************************************************************
`define HBS_CLK_HZ           40000000
`define HBS_TICK_MS          1
`define HBS_TICK_CYCLES      ((`HBS_CLK_HZ / 1000) * `HBS_TICK_MS)
`define HBS_ROT_HOLD_MS      16'h0028

`endif

// ### hw/hbs_ms_timer.sv
// millisecond tick prescaler and elapsed-ms counter
`timescale 1ns/1ps
`include "hbs_cfg.svh"
module hbs_ms_timer #(
  parameter int unsigned TICK_CYCLES = `HBS_TICK_CYCLES
) (
  // clock, reset, enable
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic ce,
  // sequencer side
  hbs_tmr_if.tmr    tmr
);

  logic [31:0]        pre_reg;      // cycles within the current ms
  logic [31:0]        pre_next;
  hbs_pkg::hbs_word_t ms_reg;       // elapsed whole ms, saturating
  hbs_pkg::hbs_word_t ms_next;

  // ****************************************************************
  // next values
  // ****************************************************************
  // the prescaler restarts with the count, so a delay of n ms is n ms
  // to the cycle rather than anywhere between n-1 and n
  always_comb begin
    pre_next = pre_reg;
    ms_next  = ms_reg;
    if (tmr.clr) begin
      pre_next = 32'h0;
      ms_next  = 16'h0;
    end else if (pre_reg == TICK_CYCLES - 1) begin
      pre_next = 32'h0;
      // saturate: a held count must never wrap back below a limit
      if (ms_reg != 16'hFFFF) begin
        ms_next = ms_reg + 16'h1;
      end
    end else begin
      pre_next = pre_reg + 32'h1;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pre_reg <= 32'h0;
      ms_reg  <= 16'h0;
    end else if (ce) begin
      pre_reg <= pre_next;
      ms_reg  <= ms_next;
    end
  end

  assign tmr.elapsed = ms_reg;

endmodule : hbs_ms_timer

// ### hw/hbs_pkg.sv
// types shared by the holding brake sequencer modules
package hbs_pkg;

  // ****************************************************************
  // sequencer states, gray coded from off through run and the rotating stop to hold
  // ****************************************************************
  typedef enum logic [2:0] {
    HBS_OFF      = 3'h0,  // motor off, brake applied
    HBS_CMD_WAIT = 3'h1,  // brake released, commands not yet allowed
    HBS_RUN      = 3'h3,  // running, commands allowed
    HBS_ROT_STOP = 3'h2,  // zero-speed stop, brake still released
    HBS_HOLD     = 3'h6   // brake applied, motor still energised
  } hbs_state_t;

  typedef logic [15:0] hbs_word_t;  // register and ms count width

endpackage : hbs_pkg

// ### hw/hbs_tmr_if.sv
// carrier between the sequencer and its millisecond timer
`timescale 1ns/1ps
interface hbs_tmr_if;
  logic                clr;      // restart the count from zero
  hbs_pkg::hbs_word_t  elapsed;  // whole ms since the last restart

  modport seq (output clr, input elapsed);
  modport tmr (input clr, output elapsed);
endinterface : hbs_tmr_if

// ### hw/hbs_top.sv
// holding brake sequencer: brake output and motor power timing
// Behaviour
// - brake drives terminal only with function 18
// - terminal polarity is selectable
// - enable off: speed picks stationary or rotating
// - enable on: release brake, energise together
// - stationary: brake drops with enable
// - stationary: energised for standstill delay after
// - rotating: zero-speed stop, brake held released
// - rotating: brake drops at threshold speed
// - rotating: brake drops on wait timeout
// - rotating: energised fixed hold after drop
// - fault: power off and brake drop immediately
`timescale 1ns/1ps
`include "hbs_cfg.svh"
module hbs_top #(
  parameter int unsigned        TICK_CYCLES = `HBS_TICK_CYCLES,
  parameter hbs_pkg::hbs_word_t ROT_HOLD_MS = `HBS_ROT_HOLD_MS
) (
  // clock, reset, enable
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire logic                     ce,
  // host and drive inputs
  input  wire logic                     servo_en,
  input  wire logic                     drive_fault,
  input  wire logic [15:0]              motor_speed,
  // register port
  input  wire logic [`HBS_ADDR_W-1:0]   reg_addr,
  input  wire logic [15:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [15:0]              reg_rdata,
  // power stage and terminal
  output logic                          brake_drive_signal,
  output logic                          motor_energize,
  output logic                          zero_speed_stop,
  output logic                          cmd_ready
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  hbs_tmr_if           tmr_if ();        // link to the ms timer
  logic                en_s1_reg;        // enable synchroniser, stage 1
  logic                en_s2_reg;        // enable synchroniser, stage 2
  hbs_pkg::hbs_word_t  cmd_dly_reg;      // release to command delay
  hbs_pkg::hbs_word_t  cmd_dly_next;
  hbs_pkg::hbs_word_t  still_dly_reg;    // standstill power-off delay
  hbs_pkg::hbs_word_t  still_dly_next;
  hbs_pkg::hbs_word_t  spd_thr_reg;      // speed threshold, 0.1 rpm
  hbs_pkg::hbs_word_t  spd_thr_next;
  hbs_pkg::hbs_word_t  wait_time_reg;    // rotating brake wait time
  hbs_pkg::hbs_word_t  wait_time_next;
  hbs_pkg::hbs_word_t  do_cfg_reg;       // terminal function and polarity
  hbs_pkg::hbs_word_t  do_cfg_next;
  hbs_pkg::hbs_word_t  rdata_reg;        // read data, one cycle late
  hbs_pkg::hbs_word_t  rdata_next;
  hbs_pkg::hbs_state_t state_reg;        // sequencer state
  hbs_pkg::hbs_state_t state_next;
  logic                hold_fixed_reg;   // hold uses the fixed time
  logic                hold_fixed_next;
  logic                release_reg;      // brake released (asserted)
  logic                release_next;
  logic                energ_reg;        // motor energised
  logic                energ_next;
  logic                zstop_reg;        // zero-speed stop request
  logic                zstop_next;
  logic                ready_reg;        // commands may be sent
  logic                ready_next;
  logic                pin_reg;          // terminal level
  logic                pin_next;
  logic                tmr_clr;          // restart ms count
  hbs_pkg::hbs_word_t  hold_lim;         // current hold limit, ms
  logic                below_thr;        // speed below threshold
  logic                fn_is_brake;      // terminal assigned to brake

  // ****************************************************************
  // clamp a written value into its legal range
  // ****************************************************************
  function automatic hbs_pkg::hbs_word_t clamp(input hbs_pkg::hbs_word_t v,
                                               input hbs_pkg::hbs_word_t lo,
                                               input hbs_pkg::hbs_word_t hi);
    hbs_pkg::hbs_word_t r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction : clamp

  // ****************************************************************
  // millisecond timer
  // ****************************************************************
  // one timer serves every delay: the phases never overlap
  hbs_ms_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .tmr  (tmr_if.tmr)
  );
  assign tmr_if.clr = tmr_clr;

  // ****************************************************************
  // servo enable synchroniser
  // ****************************************************************
  // enable comes from the host pin, so it is not on our clock
  always_ff @(posedge clk) begin
    if (!rstn) begin
      en_s1_reg <= 1'b0;
      en_s2_reg <= 1'b0;
    end else if (ce) begin
      en_s1_reg <= servo_en;
      en_s2_reg <= en_s1_reg;
    end
  end

  // ****************************************************************
  // register file: next values
  // ****************************************************************
  // out-of-range writes are clamped rather than refused, so the
  // sequencer never sees a zero or oversize delay
  always_comb begin
    cmd_dly_next   = cmd_dly_reg;
    still_dly_next = still_dly_reg;
    spd_thr_next   = spd_thr_reg;
    wait_time_next = wait_time_reg;
    do_cfg_next    = do_cfg_reg;
    rdata_next     = 16'h0;
    if (reg_wr) begin
      unique case (reg_addr)
        `HBS_OFS_CMD_DLY: begin
          cmd_dly_next = clamp(reg_wdata, `HBS_MIN_CMD_DLY, `HBS_MAX_CMD_DLY);
        end
        `HBS_OFS_STILL_DLY: begin
          still_dly_next = clamp(reg_wdata, `HBS_MIN_STILL_DLY, `HBS_MAX_STILL_DLY);
        end
        `HBS_OFS_SPD_THR: begin
          spd_thr_next = clamp(reg_wdata, `HBS_MIN_SPD_THR, `HBS_MAX_SPD_THR);
        end
        `HBS_OFS_WAIT_TIME: begin
          wait_time_next = clamp(reg_wdata, `HBS_MIN_WAIT_TIME, `HBS_MAX_WAIT_TIME);
        end
        `HBS_OFS_DO_CFG: begin
          // only the function field and polarity bit are kept
          do_cfg_next = 16'h0;
          do_cfg_next[`HBS_FN_LSB +: `HBS_FN_W] = reg_wdata[`HBS_FN_LSB +: `HBS_FN_W];
          do_cfg_next[`HBS_POL_BIT] = reg_wdata[`HBS_POL_BIT];
        end
        default: begin
          // unmapped or read-only: write ignored
        end
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `HBS_OFS_CMD_DLY:   rdata_next = cmd_dly_reg;
        `HBS_OFS_STILL_DLY: rdata_next = still_dly_reg;
        `HBS_OFS_SPD_THR:   rdata_next = spd_thr_reg;
        `HBS_OFS_WAIT_TIME: rdata_next = wait_time_reg;
        `HBS_OFS_DO_CFG:    rdata_next = do_cfg_reg;
        `HBS_OFS_STATUS: begin
          // live state of the sequencer
          rdata_next = {7'h0, state_reg, en_s2_reg, drive_fault,
                        ready_reg, zstop_reg, energ_reg, release_reg};
        end
        default: begin
          rdata_next = 16'h0;  // unmapped reads as zero
        end
      endcase
    end
  end

  // ****************************************************************
  // register file: registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmd_dly_reg   <= `HBS_RST_CMD_DLY;
      still_dly_reg <= `HBS_RST_STILL_DLY;
      spd_thr_reg   <= `HBS_RST_SPD_THR;
      wait_time_reg <= `HBS_RST_WAIT_TIME;
      do_cfg_reg    <= `HBS_RST_DO_CFG;
      rdata_reg     <= 16'h0;
    end else if (ce) begin
      cmd_dly_reg   <= cmd_dly_next;
      still_dly_reg <= still_dly_next;
      spd_thr_reg   <= spd_thr_next;
      wait_time_reg <= wait_time_next;
      do_cfg_reg    <= do_cfg_next;
      rdata_reg     <= rdata_next;
    end
  end

  // ****************************************************************
  // sequencer: next values
  // ****************************************************************
  assign below_thr   = motor_speed < spd_thr_reg;
  assign fn_is_brake = do_cfg_reg[`HBS_FN_LSB +: `HBS_FN_W] == `HBS_FN_BRAKE;
  // limits are read live, so a changed delay applies at once
  assign hold_lim    = hold_fixed_reg ? ROT_HOLD_MS : still_dly_reg;

  always_comb begin
    state_next      = state_reg;
    hold_fixed_next = hold_fixed_reg;
    tmr_clr         = 1'b0;
    if (drive_fault) begin
      // fault overrides any sequence in progress
      state_next = hbs_pkg::HBS_OFF;
      tmr_clr    = 1'b1;
    end else begin
      unique case (state_reg)
        hbs_pkg::HBS_OFF: begin
          // enable is taken as a level; a hold is always finished first
          if (en_s2_reg) begin
            state_next = hbs_pkg::HBS_CMD_WAIT;
            tmr_clr    = 1'b1;
          end
        end
        hbs_pkg::HBS_CMD_WAIT, hbs_pkg::HBS_RUN: begin
          if (!en_s2_reg) begin
            tmr_clr = 1'b1;
            if (below_thr) begin
              state_next      = hbs_pkg::HBS_HOLD;
              hold_fixed_next = 1'b0;
            end else begin
              state_next = hbs_pkg::HBS_ROT_STOP;
            end
          end else if (state_reg == hbs_pkg::HBS_CMD_WAIT &&
                       tmr_if.elapsed >= cmd_dly_reg) begin
            state_next = hbs_pkg::HBS_RUN;
          end
        end
        hbs_pkg::HBS_ROT_STOP: begin
          // whichever comes first: threshold reached or wait timed out
          if (motor_speed <= spd_thr_reg || tmr_if.elapsed >= wait_time_reg) begin
            state_next      = hbs_pkg::HBS_HOLD;
            hold_fixed_next = 1'b1;
            tmr_clr         = 1'b1;
          end
        end
        hbs_pkg::HBS_HOLD: begin
          if (tmr_if.elapsed >= hold_lim) begin
            state_next = hbs_pkg::HBS_OFF;
            tmr_clr    = 1'b1;
          end
        end
        default: begin
          // illegal code: fall back to the safe state
          state_next = hbs_pkg::HBS_OFF;
          tmr_clr    = 1'b1;
        end
      endcase
    end
    // outputs follow the next state so they change with the transition
    release_next = state_next inside {hbs_pkg::HBS_CMD_WAIT, hbs_pkg::HBS_RUN,
                                      hbs_pkg::HBS_ROT_STOP};
    energ_next   = state_next != hbs_pkg::HBS_OFF;
    zstop_next   = state_next == hbs_pkg::HBS_ROT_STOP;
    ready_next   = state_next == hbs_pkg::HBS_RUN;
    // unassigned terminal rests low whatever the polarity
    pin_next     = fn_is_brake & (release_next ^ do_cfg_reg[`HBS_POL_BIT]);
  end

  // ****************************************************************
  // sequencer: registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg      <= hbs_pkg::HBS_OFF;
      hold_fixed_reg <= 1'b0;
      release_reg    <= 1'b0;
      energ_reg      <= 1'b0;
      zstop_reg      <= 1'b0;
      ready_reg      <= 1'b0;
      pin_reg        <= 1'b0;
    end else if (ce) begin
      state_reg      <= state_next;
      hold_fixed_reg <= hold_fixed_next;
      release_reg    <= release_next;
      energ_reg      <= energ_next;
      zstop_reg      <= zstop_next;
      ready_reg      <= ready_next;
      pin_reg        <= pin_next;
    end
  end

  // ****************************************************************
  // outputs, all straight from flip-flops
  // ****************************************************************
  assign reg_rdata          = rdata_reg;
  assign brake_drive_signal = pin_reg;
  assign motor_energize     = energ_reg;
  assign zero_speed_stop    = zstop_reg;
  assign cmd_ready          = ready_reg;

endmodule : hbs_top

// ### verif/hbs_host_model.sv
// host controller and motor stand-in driving enable and speed
`timescale 1ns/1ps
module hbs_host_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // bench requests
  input  wire logic        en_req,
  input  wire logic [15:0] spd_set,
  input  wire logic [15:0] decel,
  // sequencer outputs seen by host and motor
  input  wire logic        zero_speed_stop,
  input  wire logic        cmd_ready,
  // drive inputs
  output logic             servo_en,
  output logic [15:0]      motor_speed,
  output int               cmd_sent
);
  // host: enable follows the request, motion commands only once allowed
  always_ff @(posedge clk) begin
    if (!rstn) begin
      servo_en <= 1'b0;
      cmd_sent <= 0;
    end else begin
      servo_en <= en_req;
      if (cmd_ready) begin
        cmd_sent <= cmd_sent + 1;
      end
    end
  end
  // motor: decel of zero never slows, so the wait timer has to end the stop
  always_ff @(posedge clk) begin
    if (!rstn) begin
      motor_speed <= 16'h0000;
    end else if (zero_speed_stop) begin
      motor_speed <= (motor_speed > decel) ? motor_speed - decel : 16'h0000;
    end else begin
      motor_speed <= spd_set;
    end
  end
endmodule : hbs_host_model

// ### verif/hbs_top_props.sv
// assertion checker bound to the holding brake sequencer top
`timescale 1ns/1ps
`include "hbs_cfg.svh"
module hbs_top_props #(
  parameter int unsigned        TICK_CYCLES = `HBS_TICK_CYCLES,
  parameter hbs_pkg::hbs_word_t ROT_HOLD_MS = `HBS_ROT_HOLD_MS
) (
  // clock, reset, enable
  input wire logic                   clk,
  input wire logic                   rstn,
  input wire logic                   ce,
  // host and drive inputs
  input wire logic                   servo_en,
  input wire logic                   drive_fault,
  input wire logic [15:0]            motor_speed,
  // register port
  input wire logic [`HBS_ADDR_W-1:0] reg_addr,
  input wire logic [15:0]            reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [15:0]            reg_rdata,
  // power stage and terminal
  input wire logic                   brake_drive_signal,
  input wire logic                   motor_energize,
  input wire logic                   zero_speed_stop,
  input wire logic                   cmd_ready
);
  // ****************************************
  // shadow state
  // ****************************************
  localparam int HC = int'(ROT_HOLD_MS) * int'(TICK_CYCLES); // rotating hold in cycles
  logic [15:0] cfg_reg, cfg_next;   // terminal config as written
  logic        zs_reg, zs_next;     // previous stop level
  logic        hold_reg, hold_next; // inside a rotating hold
  int          cnt_reg, cnt_next;   // cycles spent in that hold
  logic        fn_ok, rel;          // terminal assigned, brake released
  // next values; release recovered via polarity
  always_comb begin
    cfg_next  = (ce && reg_wr && reg_addr == `HBS_OFS_DO_CFG) ? reg_wdata : cfg_reg;
    zs_next   = zero_speed_stop;
    hold_next = hold_reg;
    cnt_next  = cnt_reg + 1;
    if (zs_reg && !zero_speed_stop) begin // stop just ended
      hold_next = 1'b1;
      cnt_next  = 0;
    end else if (!motor_energize) begin // power gone, hold over
      hold_next = 1'b0;
    end
    fn_ok = cfg_reg[`HBS_FN_LSB +: `HBS_FN_W] == `HBS_FN_BRAKE;
    rel   = fn_ok & (brake_drive_signal ^ cfg_reg[`HBS_POL_BIT]);
  end
  // registers only
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_reg  <= `HBS_RST_DO_CFG;
      zs_reg   <= 1'b0;
      hold_reg <= 1'b0;
      cnt_reg  <= 0;
    end else begin
      cfg_reg  <= cfg_next;
      zs_reg   <= zs_next;
      hold_reg <= hold_next;
      cnt_reg  <= cnt_next;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // enable edges, seen ahead of the synchroniser
  sequence s_en_on;  $rose(servo_en) && !motor_energize && !drive_fault; endsequence
  sequence s_powered; motor_energize || drive_fault || !servo_en; endsequence
  sequence s_en_off; $fell(servo_en) && rel && !zero_speed_stop && !drive_fault; endsequence
  sequence s_dropped; !rel || zero_speed_stop || drive_fault; endsequence
  property p_fn_gate; !fn_ok |=> !brake_drive_signal; endproperty
  property p_pol_idle;
    fn_ok && !motor_energize && $stable(cfg_reg) |-> brake_drive_signal == cfg_reg[`HBS_POL_BIT];
  endproperty
  property p_on_together; fn_ok && $rose(motor_energize) |-> rel; endproperty
  property p_en_on; s_en_on |-> ##[2:4] s_powered; endproperty
  property p_cmd_gate;
    cmd_ready |-> motor_energize && !zero_speed_stop && (rel || !fn_ok);
  endproperty
  property p_en_off; s_en_off |-> ##[2:4] s_dropped; endproperty
  property p_zstop_hold; zero_speed_stop |-> motor_energize && (rel || !fn_ok); endproperty
  property p_rot_drop;
    fn_ok && $fell(zero_speed_stop) && !drive_fault && !$past(drive_fault) |-> !rel && motor_energize;
  endproperty
  property p_rot_hold;
    hold_reg && motor_energize && !drive_fault && cnt_reg < HC - 2 |=> motor_energize;
  endproperty
  property p_rot_bound; hold_reg |-> cnt_reg <= HC + 3; endproperty
  property p_fault;
    drive_fault |=> !motor_energize && !rel && !cmd_ready && !zero_speed_stop;
  endproperty
  a_fn_gate:     assert property (p_fn_gate) else $error("fn gate");
  a_pol_idle:    assert property (p_pol_idle) else $error("idle level");
  a_on_together: assert property (p_on_together) else $error("on together");
  a_en_on:       assert property (p_en_on) else $error("enable on");
  a_cmd_gate:    assert property (p_cmd_gate) else $error("cmd gate");
  a_en_off:      assert property (p_en_off) else $error("enable off");
  a_zstop_hold:  assert property (p_zstop_hold) else $error("stop hold");
  a_rot_drop:    assert property (p_rot_drop) else $error("rot drop");
  a_rot_hold:    assert property (p_rot_hold) else $error("rot hold");
  a_rot_bound:   assert property (p_rot_bound) else $error("rot bound");
  a_fault:       assert property (p_fault) else $error("fault");
endmodule : hbs_top_props

bind hbs_top hbs_top_props #(.TICK_CYCLES(TICK_CYCLES), .ROT_HOLD_MS(ROT_HOLD_MS)) u_props (.*);

// ### verif/holding_brake_sequencer_tb_top.sv
// self-checking bench for the holding brake sequencer
`timescale 1ns/1ps
module holding_brake_sequencer_tb_top;
  localparam int TK = 4; // short ms tick keeps the run brief
  logic        clk, rstn, ce, en_req, drive_fault, reg_wr, reg_rd;
  logic [2:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, spd_set, decel, motor_speed;
  logic        servo_en, brake_drive_signal, motor_energize, zero_speed_stop, cmd_ready;
  int          n_errors, compares, cmd_sent, n, thr;
  int          m[8]; // register model by word offset
  logic [3:0]  outs; // outputs watched by wait_out
  hbs_top #(.TICK_CYCLES(TK), .ROT_HOLD_MS(16'h0028)) DUT (.*);
  hbs_host_model HOST (.*);
  assign outs = {cmd_ready, zero_speed_stop, brake_drive_signal, motor_energize};
  // expected terminal level for a released flag
  function automatic logic pin(input logic r);
    return (m[4][4:0] == 18) & (r ^ m[4][8]);
  endfunction : pin
  // writes outside the legal range land on the nearest limit
  function automatic int clampv(input int a, input int v);
    int lo[4] = '{20, 1, 0, 1};
    int hi[4] = '{500, 1000, 30000, 30000};
    if (a > 3) return v;
    return (v < lo[a]) ? lo[a] : (v > hi[a]) ? hi[a] : v;
  endfunction : clampv
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chk
  task automatic chk_span(input int lo, input int hi, input int got);
    compares++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("mismatch at %0t: expected %h..%h got %h", $time, lo, hi, got);
    end
  endtask : chk_span
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a < 5) m[a] = clampv(a, d);
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(m[a][15:0], reg_rdata);
  endtask : rd
  // counts edges until an output settles at v, bounded
  task automatic wait_out(input int w, input logic v, output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (outs[w] !== v && k < 9000);
  endtask : wait_out
  task automatic seq_still();
    @(posedge clk);
    spd_set <= 16'h0000;
    en_req  <= 1'b1;
    wait_out(0, 1'b1, n);
    chk_span(3, 5, n);
    chk(16'(pin(1'b1)), 16'(brake_drive_signal));
    wait_out(3, 1'b1, n);
    chk_span(m[0] * TK - 1, m[0] * TK + 3, n);
    @(posedge clk);
    en_req <= 1'b0;
    wait_out(1, pin(1'b0), n);
    chk_span(3, 5, n);
    chk(16'h0001, 16'(motor_energize));
    wait_out(0, 1'b0, n);
    chk_span(m[1] * TK - 1, m[1] * TK + 3, n);
  endtask : seq_still
  task automatic seq_rot(input logic [15:0] dec);
    int k;
    k = (dec == 0) ? m[3] * TK : (2000 - thr + int'(dec) - 1) / int'(dec);
    @(posedge clk);
    spd_set <= 16'h07D0;
    decel   <= dec;
    en_req  <= 1'b1;
    wait_out(3, 1'b1, n);
    @(posedge clk);
    en_req <= 1'b0;
    wait_out(2, 1'b1, n);
    chk(16'(pin(1'b1)), 16'(brake_drive_signal));
    wait_out(2, 1'b0, n);
    chk_span(k - 1, k + 3, n);
    chk(16'({motor_energize, brake_drive_signal}), 16'({1'b1, pin(1'b0)}));
    wait_out(0, 1'b0, n);
    chk_span(40 * TK - 1, 40 * TK + 3, n);
    @(posedge clk);
    spd_set <= 16'h0000;
  endtask : seq_rot
  task automatic close_out();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // watchdog well beyond the expected run length
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    close_out();
  end
  initial begin
    {rstn, en_req, drive_fault, reg_wr, reg_rd, reg_addr} = '0;
    {reg_wdata, spd_set, decel} = '0;
    ce = 1'b1;
    n_errors = 0;
    compares = 0;
    m = '{250, 150, 100, 500, 18, 0, 0, 0};
    thr = $urandom(32'h9385);
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    for (int a = 0; a < 8; a++) rd(a[2:0]);
    wr(3'h0, 16'h0005);
    wr(3'h1, 16'h07D0);
    wr(3'h3, 16'h0000);
    wr(3'h6, 16'h1234);
    for (int a = 0; a < 8; a++) rd(a[2:0]);
    thr = 50 + int'($urandom % 200);
    wr(3'h1, 16'h0003);
    wr(3'h3, 16'h00C8);
    wr(3'h2, thr[15:0]);
    rd(3'h2);
    seq_still();
    seq_rot(16'h0007);
    seq_rot(16'h0000);
    wr(3'h4, 16'h0112);
    seq_still();
    seq_rot(16'h0005);
    wr(3'h4, 16'h0000);
    @(posedge clk);
    en_req <= 1'b1;
    wait_out(0, 1'b1, n);
    chk(16'h0000, 16'(brake_drive_signal));
    @(posedge clk);
    en_req <= 1'b0;
    wait_out(0, 1'b0, n);
    wr(3'h4, 16'h0012);
    @(posedge clk);
    en_req <= 1'b1;
    wait_out(3, 1'b1, n);
    @(posedge clk);
    drive_fault <= 1'b1;
    en_req <= 1'b0;
    @(posedge clk);
    #1;
    chk(16'h0000, 16'({motor_energize, cmd_ready, brake_drive_signal}));
    repeat (6) @(posedge clk);
    drive_fault <= 1'b0;
    repeat (4) @(posedge clk);
    chk_span(1, 9000, cmd_sent);
    close_out();
  end
endmodule : holding_brake_sequencer_tb_top
